// [src/gpio_port_pkg.sv]
// Constants shared by the general-purpose port and its helpers.
// Assumes a 32-bit APB register bus and one 50 MHz clock.
package gpio_port_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned FN_WIDTH  = 3;
  localparam int unsigned INT_PIN   = 3;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [31:0] ADDR_FUNC   = 32'h0000_0000;
  localparam logic [31:0] ADDR_DIR    = 32'h0000_0004;
  localparam logic [31:0] ADDR_OUT    = 32'h0000_0008;
  localparam logic [31:0] ADDR_IN     = 32'h0000_000c;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  localparam logic [31:0] ADDR_MASK   = 32'h0000_0014;
  localparam logic [31:0] ADDR_CFG    = 32'h0000_0018;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned STAT_EDGE_BIT  = 0;
  localparam int unsigned CFG_PIPE_BIT   = 0;
  localparam int unsigned CFG_FALL_BIT   = 1;
  localparam int unsigned CFG_LOADED_BIT = 2;

  // ****************************************
  // Pin function codes
  // ****************************************
  localparam logic [2:0] FN_GPIO    = 3'h0;
  localparam logic [2:0] FN_SPI_SS  = 3'h1;
  localparam logic [2:0] FN_I2C     = 3'h2;
  localparam logic [2:0] FN_SUSPEND = 3'h3;
  localparam logic [2:0] FN_WAKEUP  = 3'h4;
  localparam logic [2:0] FN_INT     = 3'h5;

  // ****************************************
  // Configuration modes that open the pipe
  // ****************************************
  localparam logic [1:0] MODE_SETTING_ZERO = 2'h0;
  localparam logic [1:0] MODE_SETTING_ONE  = 2'h1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [11:0] RST_FUNC = 12'h000;
  localparam logic [3:0]  RST_DIR  = 4'h0;
  localparam logic [3:0]  RST_OUT  = 4'h0;
  localparam logic [0:0]  RST_MASK = 1'h0;
  // Unprogrammed edge selection means rising
  localparam logic        RST_FALL = 1'b0;

endpackage

// [src/pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// [src/edge_pending.sv]
// Edge detector with a sticky pending flag for the interrupt pin.
// Assumes level is already synchronised to pclk.
`timescale 1ns/1ps
module edge_pending (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic falling_sel,
  input  wire logic level,
  input  wire logic clear,
  output logic      pending
);

  logic prev_q;
  logic prev_d;
  logic pend_q;
  logic pend_d;
  logic hit;

  assign hit = enable && (falling_sel ? (prev_q && !level) : (!prev_q && level));

  always_comb
  begin
    prev_d = prev_q;
    pend_d = pend_q;
    if (ce)
    begin
      // Tracks while disabled so enabling never fakes an edge
      prev_d = level;
      if (hit)
        pend_d = 1'b1;
      else if (clear)
        pend_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_rise_sets;
    @(posedge pclk) disable iff (!presetn)
      (ce && enable && !falling_sel && !prev_q && level) |=> pend_q;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost");

  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn)
      (ce && enable && falling_sel && prev_q && !level) |=> pend_q;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_pend_holds;
    @(posedge pclk) disable iff (!presetn)
      (pend_q && !(ce && clear)) |=> pend_q;
  endproperty
  a_pend_holds: assert property (p_pend_holds) else $error("pending dropped early");

endmodule

// [src/usb_bridge_gpio_port.sv]
// Four-pin general-purpose port with alternate functions and
// an edge interrupt on the fourth pin, behind an APB slave.
// Assumes cfg_mode and the OTP signals come from pclk logic.
//
// Summary of operation
// - Pipe enabled only in setting zero or one
// - Each pin selects GPIO or alternate function
// - Unassigned pins behave as plain GPIO
// - Per-pin programmable direction
// - Host reads levels and writes outputs
// - Fourth pin switchable to interrupt input
// - Rising or falling edge, rising by default
// - Edge choice loaded from OTP before activity
`timescale 1ns/1ps
module usb_bridge_gpio_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cfg_mode,
  input  wire logic        otp_valid,
  input  wire logic        otp_edge_falling,
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  input  wire logic [3:0]  alt_out,
  input  wire logic [3:0]  alt_oe,
  output logic      [3:0]  alt_in,
  output logic      [11:0] func_sel,
  output logic             pipe_active,
  output logic             irq
);

  // ****************************************
  // Register state
  // ****************************************
  logic [11:0] func_q;
  logic [11:0] func_d;
  logic [3:0]  dir_q;
  logic [3:0]  dir_d;
  logic [3:0]  out_q;
  logic [3:0]  out_d;
  logic [0:0]  mask_q;
  logic [0:0]  mask_d;
  logic        fall_q;
  logic        fall_d;
  logic        loaded_q;
  logic        loaded_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic        setup;
  logic        access;
  logic        hit;
  logic        wr;
  logic        stat_clr;
  logic        pipe_en;
  logic        det_en;
  logic        edge_pend;
  logic [3:0]  level;
  logic [3:0]  pout_d;
  logic [3:0]  poe_d;
  logic [3:0]  pout_q;
  logic [3:0]  poe_q;
  logic [3:0]  alt_in_q;

  // ****************************************
  // Mode gating
  // ****************************************
  // pipe opens in two modes only
  assign pipe_en = loaded_q && ((cfg_mode == gpio_port_pkg::MODE_SETTING_ZERO) ||
                                (cfg_mode == gpio_port_pkg::MODE_SETTING_ONE));

  // ****************************************
  // APB decode
  // ****************************************
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = (paddr == gpio_port_pkg::ADDR_FUNC)   || (paddr == gpio_port_pkg::ADDR_DIR)  ||
                  (paddr == gpio_port_pkg::ADDR_OUT)    || (paddr == gpio_port_pkg::ADDR_IN)   ||
                  (paddr == gpio_port_pkg::ADDR_STATUS) || (paddr == gpio_port_pkg::ADDR_MASK) ||
                  (paddr == gpio_port_pkg::ADDR_CFG);
  // Frozen clock enable stalls the bus too
  assign pready   = ce;
  assign pslverr  = access && ce && !hit;
  assign wr       = access && ce && pwrite && hit;
  assign stat_clr = wr && (paddr == gpio_port_pkg::ADDR_STATUS) &&
                    pwdata[gpio_port_pkg::STAT_EDGE_BIT];

  always_comb
  begin
    func_d   = func_q;
    dir_d    = dir_q;
    out_d    = out_q;
    mask_d   = mask_q;
    fall_d   = fall_q;
    loaded_d = loaded_q;
    rdata_d  = rdata_q;
    if (ce)
    begin
      // edge choice taken once from OTP
      if (otp_valid && !loaded_q)
      begin
        fall_d   = otp_edge_falling;
        loaded_d = 1'b1;
      end
      if (wr)
      begin
        unique case (paddr)
          gpio_port_pkg::ADDR_FUNC: func_d = pwdata[11:0];
          gpio_port_pkg::ADDR_DIR:  dir_d  = pwdata[3:0];
          gpio_port_pkg::ADDR_OUT:  out_d  = pwdata[3:0];
          gpio_port_pkg::ADDR_MASK: mask_d = pwdata[0:0];
          default:                  ;
        endcase
      end
      // Read data loaded in setup so prdata comes from a flop
      if (setup)
      begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
          gpio_port_pkg::ADDR_FUNC:   rdata_d[11:0] = func_q;
          gpio_port_pkg::ADDR_DIR:    rdata_d[3:0]  = dir_q;
          gpio_port_pkg::ADDR_OUT:    rdata_d[3:0]  = out_q;
          gpio_port_pkg::ADDR_IN:     rdata_d[3:0]  = level;
          gpio_port_pkg::ADDR_STATUS: rdata_d[gpio_port_pkg::STAT_EDGE_BIT] = edge_pend;
          gpio_port_pkg::ADDR_MASK:   rdata_d[0:0]  = mask_q;
          gpio_port_pkg::ADDR_CFG:
          begin
            rdata_d[gpio_port_pkg::CFG_PIPE_BIT]   = pipe_en;
            rdata_d[gpio_port_pkg::CFG_FALL_BIT]   = fall_q;
            rdata_d[gpio_port_pkg::CFG_LOADED_BIT] = loaded_q;
          end
          default:                    ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_q   <= gpio_port_pkg::RST_FUNC;
      dir_q    <= gpio_port_pkg::RST_DIR;
      out_q    <= gpio_port_pkg::RST_OUT;
      mask_q   <= gpio_port_pkg::RST_MASK;
      fall_q   <= gpio_port_pkg::RST_FALL;
      loaded_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      func_q   <= func_d;
      dir_q    <= dir_d;
      out_q    <= out_d;
      mask_q   <= mask_d;
      fall_q   <= fall_d;
      loaded_q <= loaded_d;
      rdata_q  <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // ****************************************
  // Pin input path
  // ****************************************
  // two flops before any logic
  pin_sync #(
    .WIDTH (gpio_port_pkg::PIN_COUNT)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (pin_in),
    .sync_out (level)
  );

  // ****************************************
  // Pin output path
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < gpio_port_pkg::PIN_COUNT; gi++)
    begin : g_pin
      logic [2:0] fn;
      logic       alt;
      logic       intr;
      assign fn   = func_q[gi*gpio_port_pkg::FN_WIDTH +: gpio_port_pkg::FN_WIDTH];
      // interrupt code only valid on the fourth pin
      assign intr = (gi == gpio_port_pkg::INT_PIN) && (fn == gpio_port_pkg::FN_INT);
      // unknown codes fall back to GPIO
      assign alt  = (fn == gpio_port_pkg::FN_SPI_SS) || (fn == gpio_port_pkg::FN_I2C) ||
                    (fn == gpio_port_pkg::FN_SUSPEND) || (fn == gpio_port_pkg::FN_WAKEUP);
      always_comb
      begin
        pout_d[gi] = 1'b0;
        poe_d[gi]  = 1'b0;
        if (pipe_en && !intr)
        begin
          if (alt)
          begin
            pout_d[gi] = alt_out[gi];
            poe_d[gi]  = alt_oe[gi];
          end
          else
          begin
            pout_d[gi] = out_q[gi];
            poe_d[gi]  = dir_q[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pout_q   <= 4'h0;
      poe_q    <= 4'h0;
      alt_in_q <= 4'h0;
    end
    else if (ce)
    begin
      pout_q   <= pout_d;
      poe_q    <= poe_d;
      alt_in_q <= pipe_en ? level : 4'h0;
    end
  end

  assign pin_out     = pout_q;
  assign pin_oe      = poe_q;
  assign alt_in      = alt_in_q;
  assign func_sel    = func_q;
  assign pipe_active = pipe_en;

  // ****************************************
  // Interrupt
  // ****************************************
  // detection armed only in interrupt mode
  assign det_en = pipe_en && (func_q[11:9] == gpio_port_pkg::FN_INT);

  edge_pending u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .enable      (det_en),
    .falling_sel (fall_q),
    .level       (level[gpio_port_pkg::INT_PIN]),
    .clear       (stat_clr),
    .pending     (edge_pend)
  );

  // Level output, held until software clears the flag
  assign irq = edge_pend && mask_q[0];

  // ****************************************
  // Checks
  // ****************************************
  property p_pipe_off;
    @(posedge pclk) disable iff (!presetn)
      (ce && !pipe_en) |=> (pin_oe == 4'h0);
  endproperty
  a_pipe_off: assert property (p_pipe_off) else $error("pin driven with pipe closed");

  property p_alt_pass;
    @(posedge pclk) disable iff (!presetn)
      (ce && pipe_en && (func_q[2:0] == gpio_port_pkg::FN_I2C)) |=>
        (pin_oe[0] == $past(alt_oe[0])) && (pin_out[0] == $past(alt_out[0]));
  endproperty
  a_alt_pass: assert property (p_alt_pass) else $error("alternate function not routed");

  property p_gpio_default;
    @(posedge pclk) disable iff (!presetn)
      (ce && pipe_en && (func_q[5:3] == gpio_port_pkg::FN_GPIO)) |=>
        (pin_oe[1] == $past(dir_q[1])) && (pin_out[1] == $past(out_q[1]));
  endproperty
  a_gpio_default: assert property (p_gpio_default) else $error("default pin not GPIO");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && (paddr == gpio_port_pkg::ADDR_DIR)) |=> (dir_q == $past(pwdata[3:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_level_read;
    @(posedge pclk) disable iff (!presetn)
      (ce && setup && (paddr == gpio_port_pkg::ADDR_IN)) |=>
        (prdata == {28'h0000000, $past(level)});
  endproperty
  a_level_read: assert property (p_level_read) else $error("pin level read wrong");

  property p_int_input;
    @(posedge pclk) disable iff (!presetn)
      (ce && det_en) |=> !pin_oe[3];
  endproperty
  a_int_input: assert property (p_int_input) else $error("interrupt pin driven");

  property p_default_rise;
    @(posedge pclk) disable iff (!presetn)
      !loaded_q |-> !fall_q;
  endproperty
  a_default_rise: assert property (p_default_rise) else $error("edge not rising by default");

  property p_otp_fixed;
    @(posedge pclk) disable iff (!presetn)
      loaded_q |=> loaded_q && $stable(fall_q);
  endproperty
  a_otp_fixed: assert property (p_otp_fixed) else $error("edge choice changed after load");

  // Both capture edges must have run, not reset or frozen
  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      ($past(presetn, 2) && $past(presetn) && $past(ce, 2) && $past(ce)) |->
        (level == $past(pin_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency not two");

  c_edge_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_clear:    cover property (@(posedge pclk) disable iff (!presetn) edge_pend ##1 !edge_pend);
  c_output:   cover property (@(posedge pclk) disable iff (!presetn) pipe_en && (pin_oe == 4'hf));
  c_slverr:   cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

// [sim/pin_partner.sv]
// Model of the outside circuits wired to the four port pins.
// Assumes the bench sets the level that outside drivers apply.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] ext_level,
  output logic      [3:0] pin_in
);
  // ****************************************
  // Wire level
  // ****************************************
  // Outside drivers are weak, so device drive wins
  always_comb
  begin
    pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
  end
endmodule

// [sim/usb_bridge_gpio_port_tb.sv]
// Self-checking bench for the four-pin general-purpose port.
// Assumes the pin model pin_partner and a 50 MHz pclk.
`timescale 1ns/1ps
module usb_bridge_gpio_port_tb;
  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        err;
  } row_s;

  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  cfg_mode;
  logic        otp_valid;
  logic        otp_edge_falling;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  alt_out;
  logic [3:0]  alt_oe;
  logic [3:0]  alt_in;
  logic [11:0] func_sel;
  logic        pipe_active;
  logic        irq;
  logic [3:0]  ext_level;
  logic [31:0] rd_v;
  logic        err_v;
  int          errors;
  int          n_tests;
  row_s        rows [9];

  usb_bridge_gpio_port DUT (
    .pclk             (pclk),
    .presetn          (presetn),
    .ce               (ce),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .cfg_mode         (cfg_mode),
    .otp_valid        (otp_valid),
    .otp_edge_falling (otp_edge_falling),
    .pin_in           (pin_in),
    .pin_out          (pin_out),
    .pin_oe           (pin_oe),
    .alt_out          (alt_out),
    .alt_oe           (alt_oe),
    .alt_in           (alt_in),
    .func_sel         (func_sel),
    .pipe_active      (pipe_active),
    .irq              (irq)
  );

  pin_partner pins (
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .ext_level (ext_level),
    .pin_in    (pin_in)
  );

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // No cycle count assumed: the watchdog ends a stall
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd_v, exp);
  endtask

  task automatic pin3(input logic lvl, input logic exp_irq, input string name);
    ext_level[3] <= lvl;
    repeat (5) @(posedge pclk);
    check(name, 32'(irq), 32'(exp_irq));
  endtask

  task automatic otp_load(input logic fall);
    otp_edge_falling <= fall;
    otp_valid        <= 1'b1;
    @(posedge pclk);
    otp_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    check("rst_oe", 32'(pin_oe), 32'h0);
    check("rst_irq", 32'(irq), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check("pipe_pre_otp", 32'(pipe_active), 32'h0);
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    results();
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cfg_mode = 2'h0;
    otp_valid = 1'b0;
    otp_edge_falling = 1'b0;
    alt_out = 4'h0;
    alt_oe = 4'h0;
    ext_level = 4'hc;
    rows = '{'{gpio_port_pkg::ADDR_FUNC, 32'hffff_ffff, 32'h0000_0fff, 1'b0},
             '{gpio_port_pkg::ADDR_FUNC, 32'h0, 32'h0, 1'b0},
             '{gpio_port_pkg::ADDR_DIR, 32'h0000_00fa, 32'ha, 1'b0},
             '{gpio_port_pkg::ADDR_OUT, 32'h0000_0035, 32'h5, 1'b0},
             '{gpio_port_pkg::ADDR_MASK, 32'hffff_ffff, 32'h1, 1'b0},
             '{gpio_port_pkg::ADDR_MASK, 32'h0, 32'h0, 1'b0},
             '{32'h0000_001c, 32'hffff_ffff, 32'h0, 1'b1},
             '{32'h0000_0002, 32'hffff_ffff, 32'h0, 1'b1},
             '{gpio_port_pkg::ADDR_DIR, 32'h0, 32'h0, 1'b0}};
    do_reset();
    otp_load(1'b0);
    for (int m = 0; m < 4; m++)
    begin
      cfg_mode <= 2'(m);
      repeat (2) @(posedge pclk);
      check("pipe", 32'(pipe_active), 32'(m < 2));
      rd("cfg", gpio_port_pkg::ADDR_CFG, (m < 2) ? 32'h5 : 32'h4);
    end
    cfg_mode <= 2'h0;
    $display("Test modes done");
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      check("wr_err", 32'(err_v), 32'(rows[i].err));
      rd("row", rows[i].addr, rows[i].rexp);
      check("rd_err", 32'(err_v), 32'(rows[i].err));
    end
    $display("Test table done");
    wr(gpio_port_pkg::ADDR_DIR, 32'h5);
    wr(gpio_port_pkg::ADDR_OUT, 32'hf);
    repeat (3) @(posedge pclk);
    check("oe", 32'(pin_oe), 32'h5);
    check("out", 32'(pin_out & pin_oe), 32'h5);
    rd("in", gpio_port_pkg::ADDR_IN, 32'hd);
    ext_level <= 4'h0;
    // codes 1-4 hand pin zero over
    for (int c = 0; c < 8; c++)
    begin
      wr(gpio_port_pkg::ADDR_FUNC, 32'(c));
      // Pin drive, two sync flops, then the alt_in flop
      repeat (5) @(posedge pclk);
      check("func_sel", 32'(func_sel), 32'(c));
      check("oe0", 32'(pin_oe[0]), (c == 0 || c > 4) ? 32'h1 : 32'h0);
      check("alt_in0", 32'(alt_in[0]), (c == 0 || c > 4) ? 32'h1 : 32'h0);
    end
    cfg_mode <= 2'h2;
    repeat (4) @(posedge pclk);
    check("closed_oe", 32'(pin_oe), 32'h0);
    check("closed_alt", 32'(alt_in), 32'h0);
    cfg_mode <= 2'h0;
    $display("Test pins done");
    wr(gpio_port_pkg::ADDR_DIR, 32'h0);
    wr(gpio_port_pkg::ADDR_FUNC, 32'ha00);
    wr(gpio_port_pkg::ADDR_MASK, 32'h1);
    wr(gpio_port_pkg::ADDR_STATUS, 32'h1);
    pin3(1'b1, 1'b1, "irq_rise");
    pin3(1'b0, 1'b1, "irq_held");
    rd("stat", gpio_port_pkg::ADDR_STATUS, 32'h1);
    wr(gpio_port_pkg::ADDR_STATUS, 32'h1);
    pin3(1'b0, 1'b0, "irq_clr");
    wr(gpio_port_pkg::ADDR_MASK, 32'h0);
    pin3(1'b1, 1'b0, "irq_masked");
    rd("stat_m", gpio_port_pkg::ADDR_STATUS, 32'h1);
    wr(gpio_port_pkg::ADDR_MASK, 32'h1);
    pin3(1'b1, 1'b1, "irq_unmask");
    wr(gpio_port_pkg::ADDR_STATUS, 32'h1);
    wr(gpio_port_pkg::ADDR_FUNC, 32'h0);
    pin3(1'b0, 1'b0, "gpio_fall");
    pin3(1'b1, 1'b0, "gpio_rise");
    wr(gpio_port_pkg::ADDR_FUNC, 32'ha00);
    cfg_mode <= 2'h2;
    pin3(1'b0, 1'b0, "closed_fall");
    pin3(1'b1, 1'b0, "closed_rise");
    cfg_mode <= 2'h0;
    $display("Test interrupt done");
    do_reset();
    otp_load(1'b1);
    otp_load(1'b0);
    rd("cfg_fall", gpio_port_pkg::ADDR_CFG, 32'h7);
    wr(gpio_port_pkg::ADDR_FUNC, 32'ha00);
    wr(gpio_port_pkg::ADDR_MASK, 32'h1);
    pin3(1'b0, 1'b1, "fall_irq");
    wr(gpio_port_pkg::ADDR_STATUS, 32'h1);
    pin3(1'b1, 1'b0, "fall_rise");
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    check("stall", 32'(pready), 32'h0);
    ce <= 1'b1;
    $display("Test falling done");
    results();
  end
endmodule
